// ==== hdl/tudcb_pkg.sv ====
package tudcb_pkg;

	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_CONTROL = 8'hC8;
	localparam logic [7:0] IDX_MODE = 8'hC9;
	localparam logic [7:0] IDX_RELOAD_LOW = 8'hCA;
	localparam logic [7:0] IDX_RELOAD_HIGH = 8'hCB;
	localparam logic [7:0] IDX_COUNT_LOW = 8'hCC;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'hCD;
	localparam int ADDR_W = 12;

	// timer_control_register bit positions
	localparam int CTL_OVERFLOW = 7;
	localparam int CTL_EXTERNAL = 6;
	localparam int CTL_RX_SRC = 5;
	localparam int CTL_TX_SRC = 4;
	localparam int CTL_EXT_EN = 3;
	localparam int CTL_RUN = 2;
	localparam int CTL_CT_SEL = 1;
	localparam int CTL_CAP_SEL = 0;

	// timer_mode_register bit positions
	localparam int MOD_CLK_OE = 1;
	localparam int MOD_DOWN_EN = 0;

	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;

	// timing counts
	localparam logic [2:0] MC_CLOCKS = 3'h6;
	localparam logic [3:0] BAUD_DIV_LAST = 4'hF;

endpackage : tudcb_pkg

// ==== hdl/tudcb_timer.sv ====
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps

// What this block does
// - with down count enabled and direction pin high, count up, flag overflow past FFFF
// - upward overflow in up/down mode loads reload value into count
// - down counting with direction pin low underflows when count equals reload
// - underflow sets overflow flag and loads FFFF into count
// - in up/down mode external flag toggles on each overflow and underflow
// - clock out frequency is oscillator over twice (65536 minus reload)
// - clock out mode rollovers never set the overflow flag
// - transmit and receive baud come from this timer or the other, per source bits
// - baud mode rollover reloads count from reload registers
// - uart baud tick is timer overflow rate divided by 16
// - internally timed baud mode counts every oscillator clock
// - baud mode only while a source bit is set; rollover sets no flag
// - baud mode falling direction pin edge sets external flag, no reload
// - down count enable reads zero after reset
// - baud source set forces auto-reload, ignoring capture select
// - falling pin edge needs three machine cycles: high, low, then flag set
module tudcb_timer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tudcb_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic clock_pin_in,
	output logic clock_pin_out,
	output logic clock_pin_oe,
	input wire logic direction_trigger_input,
	// uart baud path
	input wire logic other_timer_overflow,
	output logic tx_baud_tick,
	output logic rx_baud_tick,
	// flag level towards the interrupt controller
	output logic timer_flag_request
);

	logic [7:0] control_reg;
	logic [7:0] control_next;
	logic [1:0] mode_reg;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [15:0] reload_reg;
	logic [15:0] reload_next;
	logic [2:0] mc_cnt_reg;
	logic pin_s1_reg;
	logic pin_s2_reg;
	logic pin_a_reg;
	logic pin_b_reg;
	logic dir_s1_reg;
	logic dir_s2_reg;
	logic dir_a_reg;
	logic dir_b_reg;
	logic clk_out_reg;
	logic [3:0] tx_div_reg;
	logic [3:0] rx_div_reg;
	logic tx_tick_reg;
	logic rx_tick_reg;
	logic [31:0] prdata_reg;

	// control fields
	wire overflow_flag = control_reg[tudcb_pkg::CTL_OVERFLOW];
	wire external_flag = control_reg[tudcb_pkg::CTL_EXTERNAL];
	wire rx_baud_source = control_reg[tudcb_pkg::CTL_RX_SRC];
	wire tx_baud_source = control_reg[tudcb_pkg::CTL_TX_SRC];
	wire external_trigger_enable = control_reg[tudcb_pkg::CTL_EXT_EN];
	wire run_control = control_reg[tudcb_pkg::CTL_RUN];
	wire timer_counter_select = control_reg[tudcb_pkg::CTL_CT_SEL];
	wire capture_reload_select = control_reg[tudcb_pkg::CTL_CAP_SEL];
	wire clock_out_enable = mode_reg[tudcb_pkg::MOD_CLK_OE];
	wire down_count_enable = mode_reg[tudcb_pkg::MOD_DOWN_EN];

	// apb decode
	wire [tudcb_pkg::ADDR_W-3:0] reg_idx = paddr[tudcb_pkg::ADDR_W-1:2];
	wire word_aligned = (paddr[1:0] == 2'h0);
	wire hit_control = word_aligned && (reg_idx == 10'(tudcb_pkg::IDX_CONTROL));
	wire hit_mode = word_aligned && (reg_idx == 10'(tudcb_pkg::IDX_MODE));
	wire hit_rl_low = word_aligned && (reg_idx == 10'(tudcb_pkg::IDX_RELOAD_LOW));
	wire hit_rl_high = word_aligned && (reg_idx == 10'(tudcb_pkg::IDX_RELOAD_HIGH));
	wire hit_cnt_low = word_aligned && (reg_idx == 10'(tudcb_pkg::IDX_COUNT_LOW));
	wire hit_cnt_high = word_aligned && (reg_idx == 10'(tudcb_pkg::IDX_COUNT_HIGH));
	wire hit_any = hit_control || hit_mode || hit_rl_low || hit_rl_high
		|| hit_cnt_low || hit_cnt_high;
	wire setup_phase = psel && !penable;
	wire access_phase = psel && penable;
	wire wr_lane0 = access_phase && pwrite && pstrb[0];
	wire wr_control = wr_lane0 && hit_control;
	wire wr_mode = wr_lane0 && hit_mode;
	wire wr_rl_low = wr_lane0 && hit_rl_low;
	wire wr_rl_high = wr_lane0 && hit_rl_high;
	wire wr_cnt_low = wr_lane0 && hit_cnt_low;
	wire wr_cnt_high = wr_lane0 && hit_cnt_high;

	// read mux; reserved bits read zero
	wire [7:0] read_byte = hit_control ? control_reg
		: hit_mode ? {6'h00, mode_reg}
		: hit_rl_low ? reload_reg[7:0]
		: hit_rl_high ? reload_reg[15:8]
		: hit_cnt_low ? count_reg[7:0]
		: hit_cnt_high ? count_reg[15:8]
		: 8'h00;

	// machine cycle enable, one clock in six
	wire mc_tick = (mc_cnt_reg == tudcb_pkg::MC_CLOCKS - 3'h1);

	// operating modes
	wire baud_mode = rx_baud_source || tx_baud_source;
	wire clkout_mode = clock_out_enable && !timer_counter_select;
	wire updown_mode = down_count_enable && !baud_mode;
	wire capture_mode = capture_reload_select && !baud_mode && !updown_mode;
	wire fast_count = !timer_counter_select && (baud_mode || clkout_mode);

	// falling edges seen over three machine cycles
	wire pin_fall = mc_tick && pin_b_reg && !pin_a_reg;
	wire dir_fall = mc_tick && dir_b_reg && !dir_a_reg;
	wire ext_edge = dir_fall && external_trigger_enable && !updown_mode;

	// counting
	wire count_src = timer_counter_select ? pin_fall : (fast_count ? 1'b1 : mc_tick);
	wire count_en = run_control && count_src;
	wire count_up = !updown_mode || dir_s2_reg;
	wire at_max = (count_reg == tudcb_pkg::COUNT_MAX);
	wire at_floor = (count_reg == reload_reg);
	wire ovf = count_en && count_up && at_max;
	wire unf = count_en && !count_up && at_floor;
	wire ovf_reload = ovf && !capture_mode;
	wire ext_reload = ext_edge && !capture_mode && !baud_mode;
	wire capture_evt = ext_edge && capture_mode;
	wire set_overflow = (ovf || unf) && !baud_mode && !clkout_mode;
	wire toggle_external = (ovf || unf) && updown_mode;
	wire selected_tx = tx_baud_source ? ovf : other_timer_overflow;
	wire selected_rx = rx_baud_source ? ovf : other_timer_overflow;

	// control register: hardware set wins over a software clear
	always_comb
	begin
		control_next = wr_control ? pwdata[7:0] : control_reg;
		if (set_overflow)
		begin
			control_next[tudcb_pkg::CTL_OVERFLOW] = 1'b1;
		end
		if (toggle_external)
		begin
			control_next[tudcb_pkg::CTL_EXTERNAL] = !control_next[tudcb_pkg::CTL_EXTERNAL];
		end
		else if (ext_edge)
		begin
			control_next[tudcb_pkg::CTL_EXTERNAL] = 1'b1;
		end
	end

	// count: software byte write, then underflow, reload, step
	always_comb
	begin
		count_next = count_reg;
		if (wr_cnt_low || wr_cnt_high)
		begin
			if (wr_cnt_low)
			begin
				count_next[7:0] = pwdata[7:0];
			end
			if (wr_cnt_high)
			begin
				count_next[15:8] = pwdata[7:0];
			end
		end
		else if (unf)
		begin
			count_next = tudcb_pkg::COUNT_MAX;
		end
		else if (ovf_reload || ext_reload)
		begin
			count_next = reload_reg;
		end
		else if (count_en)
		begin
			count_next = count_up ? count_reg + 16'h0001 : count_reg - 16'h0001;
		end
	end

	// reload: a capture takes precedence over a software write
	always_comb
	begin
		reload_next = reload_reg;
		if (capture_evt)
		begin
			reload_next = count_reg;
		end
		else
		begin
			if (wr_rl_low)
			begin
				reload_next[7:0] = pwdata[7:0];
			end
			if (wr_rl_high)
			begin
				reload_next[15:8] = pwdata[7:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			control_reg <= tudcb_pkg::CONTROL_RESET;
			mode_reg <= tudcb_pkg::MODE_RESET;
			count_reg <= tudcb_pkg::COUNT_RESET;
			reload_reg <= tudcb_pkg::RELOAD_RESET;
		end
		else
		begin
			control_reg <= control_next;
			if (wr_mode)
			begin
				mode_reg <= pwdata[1:0];
			end
			count_reg <= count_next;
			reload_reg <= reload_next;
		end
	end

	// machine cycle divider
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mc_cnt_reg <= 3'h0;
		end
		else
		begin
			mc_cnt_reg <= mc_tick ? 3'h0 : mc_cnt_reg + 3'h1;
		end
	end

	// pin synchronisers and machine cycle samplers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			dir_s1_reg <= 1'b1;
			dir_s2_reg <= 1'b1;
			pin_a_reg <= 1'b1;
			pin_b_reg <= 1'b1;
			dir_a_reg <= 1'b1;
			dir_b_reg <= 1'b1;
		end
		else
		begin
			pin_s1_reg <= clock_pin_in;
			pin_s2_reg <= pin_s1_reg;
			dir_s1_reg <= direction_trigger_input;
			dir_s2_reg <= dir_s1_reg;
			if (mc_tick)
			begin
				pin_a_reg <= pin_s2_reg;
				pin_b_reg <= pin_a_reg;
				dir_a_reg <= dir_s2_reg;
				dir_b_reg <= dir_a_reg;
			end
		end
	end

	// clock out pin toggles once per rollover
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			clk_out_reg <= 1'b0;
		end
		else if (!clkout_mode)
		begin
			clk_out_reg <= 1'b0;
		end
		else if (ovf)
		begin
			clk_out_reg <= !clk_out_reg;
		end
	end

	// baud ticks, one per sixteen selected overflows
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_div_reg <= 4'h0;
			rx_div_reg <= 4'h0;
			tx_tick_reg <= 1'b0;
			rx_tick_reg <= 1'b0;
		end
		else
		begin
			if (selected_tx)
			begin
				tx_div_reg <= tx_div_reg + 4'h1;
			end
			if (selected_rx)
			begin
				rx_div_reg <= rx_div_reg + 4'h1;
			end
			tx_tick_reg <= selected_tx && (tx_div_reg == tudcb_pkg::BAUD_DIV_LAST);
			rx_tick_reg <= selected_rx && (rx_div_reg == tudcb_pkg::BAUD_DIV_LAST);
		end
	end

	// read data is latched in the setup cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prdata_reg <= 32'h0000_0000;
		end
		else if (setup_phase && !pwrite)
		begin
			prdata_reg <= {24'h00_0000, read_byte};
		end
	end

	assign prdata = prdata_reg;
	assign pready = 1'b1;
	assign pslverr = access_phase && !hit_any;
	assign clock_pin_out = clk_out_reg;
	assign clock_pin_oe = clkout_mode;
	assign tx_baud_tick = tx_tick_reg;
	assign rx_baud_tick = rx_tick_reg;
	assign timer_flag_request = overflow_flag || external_flag;

endmodule : tudcb_timer

// ==== testbench/tudcb_timer_sva.sv ====
`timescale 1ns/10ps
module tudcb_timer_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tudcb_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins and ticks
	input wire logic clock_pin_out,
	input wire logic clock_pin_oe,
	input wire logic tx_baud_tick,
	input wire logic rx_baud_tick
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	AST_READY: assert property (psel |-> pready)
		else $error("pready low during a transfer");
	AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	AST_UNALIGN: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access not refused");
	AST_MAPPED: assert property (psel && penable && paddr == 12'h320 |-> !pslverr)
		else $error("mapped access refused");
	AST_ERR_DATA: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");
	AST_RD_UPPER: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_TX_GAP: assert property (tx_baud_tick |=> !tx_baud_tick [*8])
		else $error("tx ticks too close");
	AST_RX_GAP: assert property (rx_baud_tick |=> !rx_baud_tick [*8])
		else $error("rx ticks too close");
	AST_CLK_OFF: assert property (!clock_pin_oe && !$past(clock_pin_oe) |-> !clock_pin_out)
		else $error("clock out active while disabled");
	COV_TX: cover property (tx_baud_tick);
	COV_RX: cover property (rx_baud_tick);
	COV_CLK: cover property ($rose(clock_pin_out));
endmodule : tudcb_timer_sva

bind tudcb_timer tudcb_timer_sva u_sva (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.clock_pin_out(clock_pin_out),
	.clock_pin_oe(clock_pin_oe),
	.tx_baud_tick(tx_baud_tick),
	.rx_baud_tick(rx_baud_tick)
);

// ==== testbench/tudcb_far_timer.sv ====
`timescale 1ns/10ps
module tudcb_far_timer #(parameter int GAP = 3) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// overflow pulse of the other timer
	output logic other_timer_overflow
);
	logic [7:0] cnt_reg;
	logic last;
	assign last = (cnt_reg == 8'(GAP - 1));
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= 8'h00;
			other_timer_overflow <= 1'b0;
		end
		else
		begin
			cnt_reg <= last ? 8'h00 : cnt_reg + 8'h01;
			other_timer_overflow <= last;
		end
	end
endmodule : tudcb_far_timer

// ==== testbench/timer_updown_clkout_baudgen_tb_top.sv ====
`timescale 1ns/10ps
module timer_updown_clkout_baudgen_tb_top;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h1;
	logic dir = 1'b1;
	logic cpin = 1'b1;
	int cdiv = 0;
	logic [31:0] prdata;
	logic pready, pslverr, clk_out, clk_oe, ovf1, txt, rxt, flag_req;
	logic [31:0] r;
	logic e;
	logic [2:0] obs;
	int fails = 0;
	int samples_checked = 0;
	int n;
	assign obs = {rxt, txt, clk_out};
	always #12.5 clk_sys = ~clk_sys;
	// count pin: 24-clock period, a whole number of machine cycles
	always @(posedge clk_sys)
	begin
		cdiv <= (cdiv == 11) ? 0 : cdiv + 1;
		if (cdiv == 11)
			cpin <= ~cpin;
	end
	tudcb_far_timer far (.clk_sys(clk_sys), .rst_n(rst_n), .other_timer_overflow(ovf1));
	tudcb_timer DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clock_pin_in(cpin), .clock_pin_out(clk_out),
		.clock_pin_oe(clk_oe), .direction_trigger_input(dir), .other_timer_overflow(ovf1),
		.tx_baud_tick(txt), .rx_baud_tick(rxt), .timer_flag_request(flag_req));
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x)
		begin
			fails++;
			$display("Error %0t got %h expected %h", $time, g, x);
		end
	endtask : chk
	task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : acc
	task wr(input logic [7:0] i, input logic [7:0] d);
		acc(1'b1, {2'h0, i, 2'h0}, d);
	endtask : wr
	task rd(input logic [7:0] i, input logic [7:0] x);
		acc(1'b0, {2'h0, i, 2'h0}, 8'h00);
		chk(r, {24'h000000, x});
	endtask : rd
	task ld(input logic [7:0] i, input logic [15:0] v);
		wr(i, v[7:0]);
		wr(i + 8'h01, v[15:8]);
	endtask : ld
	task cyc;
		@(posedge clk_sys);
		#1;
	endtask : cyc
	task gap(input int b, input logic v);
		int w;
		for (w = 0; obs[b] !== 1'b0 && w < 3000; w++) cyc();
		for (w = 0; obs[b] !== 1'b1 && w < 3000; w++) cyc();
		n = 0;
		do
		begin
			cyc();
			n++;
		end
		while (obs[b] !== v && n < 3000);
	endtask : gap
	initial
	begin
		#400000;
		fails++;
		close_out();
	end
	initial
	begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(tudcb_pkg::IDX_MODE, 8'h00);
		rd(tudcb_pkg::IDX_CONTROL, 8'h00);
		wr(tudcb_pkg::IDX_MODE, 8'h01);
		ld(tudcb_pkg::IDX_RELOAD_LOW, 16'hFFF0);
		ld(tudcb_pkg::IDX_COUNT_LOW, 16'hFFFE);
		wr(tudcb_pkg::IDX_CONTROL, 8'h04);
		repeat (60) @(posedge clk_sys);
		rd(tudcb_pkg::IDX_CONTROL, 8'hC4);
		chk(flag_req, 1);
		rd(tudcb_pkg::IDX_COUNT_HIGH, 8'hFF);
		wr(tudcb_pkg::IDX_CONTROL, 8'h00);
		dir <= 1'b0;
		ld(tudcb_pkg::IDX_RELOAD_LOW, 16'h1000);
		ld(tudcb_pkg::IDX_COUNT_LOW, 16'h1002);
		wr(tudcb_pkg::IDX_CONTROL, 8'h04);
		repeat (40) @(posedge clk_sys);
		rd(tudcb_pkg::IDX_CONTROL, 8'hC4);
		rd(tudcb_pkg::IDX_COUNT_HIGH, 8'hFF);
		wr(tudcb_pkg::IDX_CONTROL, 8'h00);
		wr(tudcb_pkg::IDX_MODE, 8'h02);
		ld(tudcb_pkg::IDX_RELOAD_LOW, 16'hFFFC);
		wr(tudcb_pkg::IDX_CONTROL, 8'h04);
		chk(clk_oe, 1);
		gap(0, 1'b0);
		chk(n, 4);
		rd(tudcb_pkg::IDX_CONTROL, 8'h04);
		chk(flag_req, 0);
		wr(tudcb_pkg::IDX_CONTROL, 8'h00);
		wr(tudcb_pkg::IDX_MODE, 8'h00);
		ld(tudcb_pkg::IDX_RELOAD_LOW, 16'hFFFE);
		wr(tudcb_pkg::IDX_CONTROL, 8'h1D);
		gap(1, 1'b1);
		chk(n, 32);
		gap(2, 1'b1);
		chk(n, 48);
		dir <= 1'b1;
		repeat (30) @(posedge clk_sys);
		dir <= 1'b0;
		repeat (30) @(posedge clk_sys);
		rd(tudcb_pkg::IDX_CONTROL, 8'h5D);
		wr(tudcb_pkg::IDX_CONTROL, 8'h00);
		// counter mode baud: 16 overflows of two pin periods of 24 clocks
		wr(tudcb_pkg::IDX_CONTROL, 8'h16);
		gap(1, 1'b1);
		chk(n, 768);
		wr(tudcb_pkg::IDX_CONTROL, 8'h00);
		acc(1'b0, 12'h300, 8'h00);
		chk(e, 1);
		chk(r, 0);
		acc(1'b0, 12'h322, 8'h00);
		chk(e, 1);
		close_out();
	end
endmodule : timer_updown_clkout_baudgen_tb_top
